/* watchdog_reload_timer_tb_top.sv */
// Testbench of the watchdog reload timer: APB master, option levels.
// Assumes wdr_pkg, wdr_timer, the checker and the CPU model compile first.
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module watchdog_reload_timer_tb_top
	import wdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, rst_b = 1'h0, kick = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic trs = 1'h0, dbg = 1'h0, stp = 1'h0, osc = 1'h1;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, se, refresh_instr, irq;
	logic exception_req, reset_req, stop_recovery;
	logic wdt_status_set, stop_flag_set;
	logic [4:0] ev;
	int err_total = 0, cmp_count = 0, n;

	// The 200 MHz clock and the packed time-out report.
	always #2.5 ref_clk = ~ref_clk;
	assign ev = {exception_req, reset_req, stop_recovery, wdt_status_set,
		stop_flag_set};

	wdr_cpu_model u_cpu (.ref_clk, .rst_b, .kick, .refresh_instr);
	wdr_timer uut (.ref_clk, .rst_b, .clk_en(1'h1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.refresh_instr, .always_on_option(1'h0), .rc_osc_enable(osc),
		.timeout_response_select(trs), .debug_mode(dbg), .stop_mode(stp),
		.exception_req, .reset_req, .stop_recovery, .wdt_status_set,
		.stop_flag_set, .irq);

	// ====================
	// Bus and helper tasks
	// ====================
	// One APB transfer, held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [13:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {18'h0, a};
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do @(posedge ref_clk); while (pready !== 1'h1 && n++ < 40);
		if (n > 40)
			err_total++;
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rchk(input logic [13:0] a, input logic [7:0] e);
		apb(1'h0, a, 8'h00);
		`CHK("read data", {24'h0, e}, rd)
	endtask

	task automatic load(input logic [15:0] v);
		apb(1'h1, ADDR_RELOAD_HIGH, UNLOCK_FIRST);
		apb(1'h1, ADDR_RELOAD_HIGH, UNLOCK_SECOND);
		apb(1'h1, ADDR_RELOAD_HIGH, v[15:8]);
		apb(1'h1, ADDR_RELOAD_LOW, v[7:0]);
	endtask

	task automatic do_kick;
		@(posedge ref_clk);
		kick <= 1'h1;
		@(posedge ref_clk);
		kick <= 1'h0;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic wait_ev(input logic [4:0] e);
		n = 0;
		do @(posedge ref_clk); while (ev === 5'h00 && n++ < 21000);
		`CHK("time-out report", e, ev)
	endtask

	// ====================
	// Scenarios
	// ====================
	task automatic t_locked;
		rchk(ADDR_RELOAD_HIGH, RST_RELOAD_HIGH);
		rchk(ADDR_RELOAD_LOW, RST_RELOAD_LOW);
		apb(1'h1, 14'h3FFC, 8'h01);
		`CHK("unmapped error", 1'h1, se)
		apb(1'h1, ADDR_RELOAD_HIGH, 8'h12);
		apb(1'h1, ADDR_RELOAD_LOW, 8'h34);
		apb(1'h1, ADDR_RELOAD_HIGH, UNLOCK_FIRST);
		apb(1'h1, ADDR_RELOAD_LOW, 8'h56);
		apb(1'h1, ADDR_RELOAD_HIGH, UNLOCK_SECOND);
		apb(1'h1, ADDR_RELOAD_HIGH, 8'h78);
		apb(1'h1, ADDR_RELOAD_LOW, 8'h9A);
		do_kick();
		rchk(ADDR_RELOAD_HIGH, 8'h04);
		rchk(ADDR_RELOAD_LOW, 8'h00);
		`CHK("irq masked", 1'h0, irq)
		rchk(ADDR_IRQ_STATUS, 8'h04);
	endtask

	task automatic t_reload;
		load(16'h1234);
		do_kick();
		rchk(ADDR_RELOAD_HIGH, 8'h12);
		rchk(ADDR_RELOAD_LOW, 8'h34);
		load(16'h0001);
		apb(1'h1, ADDR_CONTROL, 8'h01);
		rchk(ADDR_RELOAD_LOW, 8'h01);
		apb(1'h1, ADDR_IRQ_MASK, 8'h01);
	endtask

	task automatic t_timeouts;
		wait_ev(5'h10);
		repeat (2) @(posedge ref_clk);
		`CHK("irq raised", 1'h1, irq)
		rchk(ADDR_RELOAD_LOW, 8'h01);
		rchk(ADDR_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge ref_clk);
		`CHK("irq cleared", 1'h0, irq)
		trs <= 1'h1;
		stp <= 1'h1;
		apb(1'h1, ADDR_IRQ_MASK, 8'h00);
		wait_ev(5'h07);
		repeat (3) @(posedge ref_clk);
		`CHK("irq masked", 1'h0, irq)
		apb(1'h1, ADDR_IRQ_MASK, 8'h02);
		repeat (2) @(posedge ref_clk);
		`CHK("irq unmasked", 1'h1, irq)
		trs <= 1'h0;
		wait_ev(5'h17);
		trs <= 1'h1;
		stp <= 1'h0;
		wait_ev(5'h0A);
		// A reset in mid-run brings the counter back to its reset value.
		rst_b <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'h1;
		rchk(ADDR_RELOAD_HIGH, RST_RELOAD_HIGH);
		rchk(ADDR_RELOAD_LOW, RST_RELOAD_LOW);
		`CHK("irq after reset", 1'h0, irq)
	endtask

	task automatic t_debug;
		// Debug first, then a short reload, so a missed refresh would
		// time out inside the observed window.
		osc <= 1'h0;
		dbg <= 1'h1;
		load(16'h0001);
		do_kick();
		repeat (50) @(posedge ref_clk);
		osc <= 1'h1;
		n = 0;
		repeat (21000) @(posedge ref_clk) if (ev !== 5'h00) n++;
		`CHK("debug time-outs", 0, n)
		dbg <= 1'h0;
	endtask

	task automatic close_out;
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence after six cycles of reset.
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'h1;
		t_locked();
		t_reload();
		t_timeouts();
		t_debug();
		close_out();
	end

	// Cuts a hang short well past the expected run length.
	initial
	begin
		#700000;
		err_total++;
		close_out();
	end
endmodule // watchdog_reload_timer_tb_top

`default_nettype wire

/* wdr_cpu_model.sv */
// CPU-side model: turns a one-cycle refresh request into one refresh pulse.
// Assumes the block's single clock and its asynchronous reset.
`default_nettype none

module wdr_cpu_model (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic kick,
	output var  logic refresh_instr
);
	timeunit 1ns;
	timeprecision 1ps;

	// A one-cycle request executes the refresh instruction once; a held request repeats it every other cycle.
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			refresh_instr <= 1'h0;
		else
			refresh_instr <= kick && !refresh_instr;
endmodule // wdr_cpu_model

`default_nettype wire

/* wdr_pkg.sv */
// Package for the watchdog reload timer: register map, reset values,
// unlock codes and timing constants.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package wdr_pkg;

	// ==========================================================
	// Register map (byte addresses on the APB port)
	// ==========================================================
	// Printed offsets are not multiples of four, so each is an index.
	localparam logic [11:0] IDX_RELOAD_HIGH = 12'hFF2;
	localparam logic [11:0] IDX_RELOAD_LOW  = 12'hFF3;
	localparam logic [11:0] IDX_IRQ_STATUS  = 12'hFF4;
	localparam logic [11:0] IDX_IRQ_MASK    = 12'hFF5;
	localparam logic [11:0] IDX_CONTROL     = 12'hFF6;
	localparam logic [13:0] ADDR_RELOAD_HIGH = {IDX_RELOAD_HIGH, 2'b00};
	localparam logic [13:0] ADDR_RELOAD_LOW  = {IDX_RELOAD_LOW, 2'b00};
	localparam logic [13:0] ADDR_IRQ_STATUS  = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [13:0] ADDR_IRQ_MASK    = {IDX_IRQ_MASK, 2'b00};
	localparam logic [13:0] ADDR_CONTROL     = {IDX_CONTROL, 2'b00};

	// ==========================================================
	// Reset values and unlock codes
	// ==========================================================
	localparam logic [7:0] RST_RELOAD_HIGH = 8'h04;
	localparam logic [7:0] RST_RELOAD_LOW  = 8'h00;
	localparam logic [7:0] UNLOCK_FIRST    = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND   = 8'hAA;
	localparam logic [2:0] RST_IRQ_MASK    = 3'h0;

	// ==========================================================
	// Field positions
	// ==========================================================
	// Status and mask: timeout, stop recovery, unlock abort.
	localparam int BIT_EV_TIMEOUT = 0;
	localparam int BIT_EV_STOP    = 1;
	localparam int BIT_EV_ABORT   = 2;
	// Control register: refresh strobe (write one to refresh).
	localparam int BIT_CTL_REFRESH = 0;

	// ==========================================================
	// Timing: oscillator tick derived from the 200 MHz clock
	// ==========================================================
	localparam int CLK_HZ      = 200000000;
	localparam int OSC_HZ      = 10000;
	localparam int OSC_DIV     = CLK_HZ / OSC_HZ;

	// Unlock sequence states.
	typedef enum logic [3:0] {
		UL_LOCKED = 4'b0001,
		UL_GOT55  = 4'b0010,
		UL_OPEN   = 4'b0100,
		UL_HIGHWR = 4'b1000
	} wdr_unlock_t;

endpackage : wdr_pkg

`default_nettype wire

/* wdr_timer.sv */
// Watchdog reload timer with APB register port, unlock sequence and a
// level interrupt for its own events.
// Assumes the oscillator tick is made from ref_clk; the option bits,
// debug, stop and oscillator enable levels are synchronous inputs.
`default_nettype none

module wdr_timer
	import wdr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        refresh_instr,
	input  wire logic        always_on_option,
	input  wire logic        rc_osc_enable,
	input  wire logic        timeout_response_select,
	input  wire logic        debug_mode,
	input  wire logic        stop_mode,
	output var  logic        exception_req,
	output var  logic        reset_req,
	output var  logic        stop_recovery,
	output var  logic        wdt_status_set,
	output var  logic        stop_flag_set,
	output var  logic        irq
);

	// ==========================================================
	// State
	// ==========================================================
	logic [15:0]  count;
	logic         running;
	logic [7:0]   reload_high_byte;
	logic [7:0]   reload_low_byte;
	logic [7:0]   pending_high;
	logic [2:0]   irq_status;
	logic [2:0]   irq_mask;
	logic [15:0]  osc_cnt;
	logic         osc_tick;
	wdr_unlock_t  ul_state;
	wdr_unlock_t  next_ul_state;

	// ==========================================================
	// Bus decode
	// ==========================================================
	// Every access is answered in its first access cycle.
	wire         acc        = psel & penable;
	wire         wr         = acc & pwrite;
	wire         rd         = acc & ~pwrite;
	wire [13:0]  a          = paddr[13:0];
	wire         hit_high   = (a == ADDR_RELOAD_HIGH);
	wire         hit_low    = (a == ADDR_RELOAD_LOW);
	wire         hit_stat   = (a == ADDR_IRQ_STATUS);
	wire         hit_mask   = (a == ADDR_IRQ_MASK);
	wire         hit_ctl    = (a == ADDR_CONTROL);
	wire         hit_any    = hit_high | hit_low | hit_stat | hit_mask
		| hit_ctl;
	wire         upper_ok   = (paddr[31:14] == 18'h00000);
	wire         mapped     = hit_any & upper_ok;
	wire [7:0]   wbyte      = pwdata[7:0];
	wire         wr_high    = wr & mapped & hit_high;
	wire         wr_low     = wr & mapped & hit_low;
	wire         sw_refresh = wr & mapped & hit_ctl
		& pwdata[BIT_CTL_REFRESH];
	wire         rd_stat    = rd & mapped & hit_stat;

	// ==========================================================
	// Unlock sequence
	// ==========================================================
	// Any out-of-order high write drops back to locked; low byte is
	// only accepted straight after the new high byte.
	wire commit_low = wr_low & (ul_state == UL_HIGHWR);
	wire ul_abort   = (wr_high & (ul_state == UL_HIGHWR))
		| (wr_high & (ul_state == UL_LOCKED) & (wbyte != UNLOCK_FIRST))
		| (wr_high & (ul_state == UL_GOT55) & (wbyte != UNLOCK_SECOND))
		| (wr_low & (ul_state != UL_HIGHWR));

	always_comb
	begin
		next_ul_state = ul_state;
		case (ul_state)
			UL_LOCKED:
			begin
				if (wr_high && wbyte == UNLOCK_FIRST)
					next_ul_state = UL_GOT55;
				else if (wr_low)
					next_ul_state = UL_LOCKED;
			end
			UL_GOT55:
			begin
				if (wr_high)
					next_ul_state = (wbyte == UNLOCK_SECOND)
						? UL_OPEN : UL_LOCKED;
				else if (wr_low)
					next_ul_state = UL_LOCKED;
			end
			UL_OPEN:
			begin
				if (wr_high)
					next_ul_state = UL_HIGHWR;
				else if (wr_low)
					next_ul_state = UL_LOCKED;
			end
			UL_HIGHWR:
			begin
				if (wr_high || wr_low)
					next_ul_state = UL_LOCKED;
			end
			default:
				next_ul_state = UL_LOCKED;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			ul_state <= UL_LOCKED;
		else if (clk_en)
			ul_state <= next_ul_state;
	end

	// Stage the high byte; both bytes land together on the low write,
	// so a broken sequence never alters the stored value.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			pending_high <= RST_RELOAD_HIGH;
		else if (clk_en && wr_high && ul_state == UL_OPEN)
			pending_high <= wbyte;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reload_high_byte <= RST_RELOAD_HIGH;
			reload_low_byte  <= RST_RELOAD_LOW;
		end
		else if (clk_en && commit_low)
		begin
			reload_high_byte <= pending_high;
			reload_low_byte  <= wbyte;
		end
	end

	// ==========================================================
	// Oscillator tick
	// ==========================================================
	// Stands in for the dedicated RC oscillator: one tick per period.
	wire osc_wrap = (osc_cnt == 16'(OSC_DIV - 1));

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			osc_cnt  <= 16'h0000;
			osc_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			osc_cnt  <= (osc_wrap || !rc_osc_enable)
				? 16'h0000 : osc_cnt + 16'h0001;
			osc_tick <= osc_wrap & rc_osc_enable;
		end
	end

	// ==========================================================
	// Counter
	// ==========================================================
	wire [15:0] reload_value = {reload_high_byte, reload_low_byte};
	wire        start        = ~running
		& (refresh_instr | sw_refresh | always_on_option);
	wire        reload_now   = start | (running
		& (refresh_instr | sw_refresh | debug_mode));
	wire        step         = running & osc_tick & rc_osc_enable
		& ~debug_mode;
	wire        hits_zero    = step & (count == 16'h0001);
	wire        timeout      = hits_zero & ~reload_now;
	wire        resp_reset   = timeout_response_select;

	// Once running, nothing but a reset clears it.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			running <= 1'b0;
		else if (clk_en && start)
			running <= 1'b1;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			count <= {RST_RELOAD_HIGH, RST_RELOAD_LOW};
		else if (clk_en)
		begin
			if (reload_now || timeout)
				count <= reload_value;
			else if (step)
				count <= count - 16'h0001;
		end
	end

	// ==========================================================
	// Timeout responses
	// ==========================================================
	// One-cycle request pulses to the interrupt, reset and stop logic.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			exception_req  <= 1'b0;
			reset_req      <= 1'b0;
			stop_recovery  <= 1'b0;
			wdt_status_set <= 1'b0;
			stop_flag_set  <= 1'b0;
		end
		else if (clk_en)
		begin
			exception_req  <= timeout & ~resp_reset;
			reset_req      <= timeout & resp_reset & ~stop_mode;
			stop_recovery  <= timeout & stop_mode;
			wdt_status_set <= timeout & (resp_reset | stop_mode);
			stop_flag_set  <= timeout & stop_mode;
		end
	end

	// ==========================================================
	// Interrupt status and mask
	// ==========================================================
	// A new event in the clearing read's cycle survives the clear.
	wire [2:0] events = {ul_abort, timeout & stop_mode, timeout};

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_status <= 3'h0;
		else if (clk_en)
			irq_status <= (rd_stat ? 3'h0 : irq_status) | events;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_mask <= RST_IRQ_MASK;
		else if (clk_en && wr && mapped && hit_mask)
			irq_mask <= pwdata[2:0];
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(irq_status & irq_mask);
	end

	// ==========================================================
	// Read data and bus answer
	// ==========================================================
	// Reload addresses read the live counter bytes.
	wire [7:0] rd_byte =
		hit_high ? count[15:8] :
		hit_low  ? count[7:0]  :
		hit_stat ? {5'h00, irq_status} :
		hit_mask ? {5'h00, irq_mask} :
		8'h00;

	// pready rises in the first access cycle and drops the cycle after.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else if (clk_en)
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel && !penable && !pwrite && mapped)
				? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

endmodule : wdr_timer

`default_nettype wire

/* wdr_timer_assertions.sv */
// Checker of the watchdog reload timer outputs and APB answer.
// Assumes it is bound to wdr_timer and sees only that module's ports.
`default_nettype none

module wdr_timer_chk (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic rc_osc_enable,
	input wire logic timeout_response_select,
	input wire logic debug_mode,
	input wire logic stop_mode,
	input wire logic exception_req,
	input wire logic reset_req,
	input wire logic stop_recovery,
	input wire logic wdt_status_set,
	input wire logic stop_flag_set
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ====================
	// Time-out reports and APB answer
	// ====================
	// A stop-mode time-out reports recovery and both flags together.
	sequence s_stop_flags;
		stop_recovery && wdt_status_set && stop_flag_set;
	endsequence
	// An exception request is followed by at least eight quiet cycles.
	sequence s_quiet;
		!exception_req [*8];
	endsequence

	a_apb_no_wait: assert property (psel && !penable |=> pready)
		else $error("pready missing in first access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_exc_mode: assert property (exception_req |->
		!$past(timeout_response_select) && !reset_req)
		else $error("exception request in reset mode");
	a_exc_spacing: assert property (exception_req |=> s_quiet)
		else $error("exception request repeated too soon");
	a_reset_mode: assert property (reset_req |->
		$past(timeout_response_select) && !$past(stop_mode)
		&& wdt_status_set)
		else $error("reset request without reset mode or flag");
	a_stop_report: assert property (stop_recovery |-> s_stop_flags)
		else $error("stop recovery without both flags");
	a_stop_cause: assert property (stop_flag_set |->
		$past(stop_mode) && !reset_req)
		else $error("stop flag outside stop mode");
	a_debug_quiet: assert property (debug_mode && $past(debug_mode) |->
		!exception_req && !reset_req && !stop_recovery)
		else $error("time-out while in debug mode");
	a_osc_off: assert property (!$past(rc_osc_enable) |->
		!exception_req && !reset_req)
		else $error("time-out with oscillator disabled");
endmodule // wdr_timer_chk

bind wdr_timer wdr_timer_chk u_chk (.ref_clk, .rst_b, .psel, .penable,
	.pready, .rc_osc_enable, .timeout_response_select, .debug_mode,
	.stop_mode, .exception_req, .reset_req, .stop_recovery,
	.wdt_status_set, .stop_flag_set);

`default_nettype wire
